/* File: mfc_defines.svh */
// Constants of the multi-mode frequency counter core.
`ifndef MFC_DEFINES_SVH
`define MFC_DEFINES_SVH
`define MFC_CLK_HZ      100000000
`define MFC_DIV_10M     100000
`define MFC_DIV_1M      10000
`define MFC_REF_MS      10
`define MFC_GAP_MS      200
`define MFC_EXT_MIN_HZ  100000
`define MFC_CNT_MAX     27'h5F5E0FF
`define MFC_ADDR_CTRL   8'h00
`define MFC_ADDR_STAT   8'h04
`define MFC_ADDR_RES    8'h08
`define MFC_ADDR_LIVE   8'h0C
`define MFC_R1_MAX      10'h000
`define MFC_R10_MAX     10'h009
`define MFC_R100_MAX    10'h063
`define MFC_R1K_MAX     10'h3E7
`define MFC_RNG_EXT     3'h4
`define MFC_PT_NONE     4'h0
`define MFC_PT_BASE     4'h2
`endif

/* File: mfc_pkg.sv */
// Types of the multi-mode frequency counter core.
package mfc_pkg;
  typedef enum logic [2:0] {
    FN_FREQ, FN_PERIOD, FN_RATIO, FN_INTERVAL, FN_UNIT, FN_OSC
  } mfc_func_t;
  typedef enum logic [1:0] {ST_ARM, ST_RUN, ST_STORE, ST_GAP} mfc_state_t;
  typedef struct packed {
    mfc_func_t  func;
    logic [2:0] rng;
    logic       disp_off;
    logic       disp_test;
    logic       mhz1;
    logic       ext_osc;
    logic       ext_point;
    logic [2:0] point_digit;
    logic [2:0] sa;
    logic [2:0] sb;
    logic [1:0] sg;
    logic [2:0] st;
    logic [16:0] div;
    logic [9:0] refcnt;
    logic [4:0] gap;
    logic [9:0] wd;
    logic [26:0] main;
    logic       ovf;
    logic [26:0] result;
    logic       res_ovf;
    mfc_state_t state;
    logic       ti_open;
    logic       fallback;
    mfc_func_t  prev_func;
    logic [2:0] prev_rng;
    logic [31:0] prdata;
  } mfc_regs_t;
endpackage

/* File: mfc_core.sv */
// Measurement core of the multi-mode frequency counter with an APB slave.
`timescale 1ns/100ps
`default_nettype none
`include "mfc_defines.svh"
module mfc_core #(
  parameter int DIV_10M = `MFC_DIV_10M,
  parameter int DIV_1M  = `MFC_DIV_1M
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        input_a,
  input  wire logic        input_b,
  input  wire logic        alt_timebase_in,
  input  wire logic        external_gate,
  input  wire logic        freeze_in,
  output logic             measurement_active,
  output logic             display_blank,
  output logic             display_test,
  output logic             overflow,
  output logic [3:0]       decimal_point_digit
);

  // ****************************************************************
  // Overview
  // ****************************************************************

  // The core routes input A, input B or the timebase into two counters. The main counter
  // holds the value that is later shown, and the reference counter decides how long the
  // main counter may run. Which signal goes where depends only on the function field.
  //
  // A measurement walks through four phases. In the armed phase the core waits for the
  // first reference event, so that every window starts on a clean boundary. In the run
  // phase the main counter accumulates until the chosen number of reference events has
  // been seen, or until the external gate is found low at a reference tick. The store
  // phase lasts one cycle and copies the count into the result. The pause phase then
  // waits a fixed number of reference ticks before arming again.
  //
  // The internal timebase is the clock itself, so one clock cycle is one timebase tick.
  // With the alternate timebase selected, each rising edge of that input is one tick, and
  // the clock only samples it. The alternate input must therefore stay well below half
  // the clock rate, or edges are lost and the reading comes out low.
  //
  // The measured inputs pass two synchronising flops before a third one that only serves
  // edge detection. This costs two cycles of latency on every counted edge. Because the
  // delay is the same for A and B, interval readings are not skewed by it.
  //
  // Any change of function or range throws the running window away. The result is kept,
  // so the display never shows a count taken partly under the old selection. In unit
  // mode a range change is harmless and is ignored, while a function change still aborts.
  //
  // The freeze input stops a window that has not reached the store phase, except in unit
  // mode, where only the result is held and the count keeps running unless the display
  // off option is also set. A store that is already under way completes despite the freeze, so a
  // result is never half written.
  //
  // Software sees four word registers: control, status, the latched result and the live
  // main counter. Read data is captured during the setup cycle, so the slave answers
  // without wait states and the read value is a flop output.
  //
  // The result is a plain binary count, not decimal. It saturates at the largest count
  // that eight decimal digits can show, and the overflow flag is then set.

  // ****************************************************************
  // Derived constants
  // ****************************************************************

  // Last reference period count of the pause between measurements.
  localparam logic [4:0] GAP_MAX = 5'(`MFC_GAP_MS / `MFC_REF_MS - 1);
  // Longest gap between alternate timebase edges, in clock cycles.
  localparam int WD_CYC = `MFC_CLK_HZ / `MFC_EXT_MIN_HZ;
  // The watchdog fires in the last edge-free cycle of a source at exactly the lowest
  // rate, so a timebase at that rate counts as too slow as well.
  localparam logic [9:0] WD_MAX = 10'(WD_CYC - 2);
  localparam logic [16:0] DIV10_MAX = 17'(DIV_10M - 1);
  localparam logic [16:0] DIV1_MAX = 17'(DIV_1M - 1);

  mfc_pkg::mfc_regs_t r_reg;
  mfc_pkg::mfc_regs_t r_next;

  logic        setup;
  logic        wr_en;
  logic        a_fall;
  logic        b_fall;
  logic        alt_rise;
  logic        gate_hi;
  logic        tb;
  logic        ref_tick;
  logic        main_ev;
  logic        ref_ev;
  logic        ext_rng;
  logic        abort;
  logic        start;
  logic        done;
  logic        count_en;
  logic        off_hold;
  logic [9:0]  rmax;
  logic [16:0] div_max;

  // ****************************************************************
  // APB handshake
  // ****************************************************************

  // Zero wait states; an unmapped address answers with an error.
  assign pready = 1'b1;
  assign prdata = r_reg.prdata;
  assign pslverr = psel & penable & ~(paddr == `MFC_ADDR_CTRL || paddr == `MFC_ADDR_STAT ||
                   paddr == `MFC_ADDR_RES || paddr == `MFC_ADDR_LIVE);
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite;

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // High only in the store and pause phases, low while measuring.
  assign measurement_active = (r_reg.state == mfc_pkg::ST_STORE) |
                              (r_reg.state == mfc_pkg::ST_GAP);
  // Display off needs both the option and the freeze input.
  assign off_hold = r_reg.disp_off & freeze_in;
  assign display_blank = off_hold;
  assign display_test = r_reg.disp_test & ~off_hold;
  assign overflow = r_reg.res_ovf;

  // Point position per mode and range, or the manual digit; none under the external gate otherwise.
  always_comb begin
    decimal_point_digit = `MFC_PT_NONE;
    if (r_reg.ext_point) begin
      decimal_point_digit = {1'b0, r_reg.point_digit} + 4'h1;
    end else if (r_reg.rng != `MFC_RNG_EXT) begin
      unique case (r_reg.func)
        mfc_pkg::FN_UNIT: decimal_point_digit = 4'h1;
        mfc_pkg::FN_RATIO: decimal_point_digit = {2'b00, r_reg.rng[1:0]} + 4'h1;
        mfc_pkg::FN_PERIOD,
        mfc_pkg::FN_INTERVAL: begin
          // Microsecond digit moves the point one place right.
          decimal_point_digit = {2'b00, r_reg.rng[1:0]} + `MFC_PT_BASE -
                                {3'b000, r_reg.mhz1};
        end
        default: decimal_point_digit = {2'b00, r_reg.rng[1:0]} + `MFC_PT_BASE;
      endcase
    end
  end

  // ****************************************************************
  // Event decode
  // ****************************************************************

  // Edges are taken from the second and third synchroniser stages.
  assign a_fall = r_reg.sa[2] & ~r_reg.sa[1];
  assign b_fall = r_reg.sb[2] & ~r_reg.sb[1];
  assign alt_rise = ~r_reg.st[2] & r_reg.st[1];
  assign gate_hi = r_reg.sg[1];
  // The internal timebase is the clock itself; the alternate one is edge counted.
  assign tb = r_reg.ext_osc ? alt_rise : 1'b1;
  assign div_max = r_reg.mhz1 ? DIV1_MAX : DIV10_MAX;
  // Greater-or-equal catches a divider left above the new limit when the 1MHz option is
  // switched on; an exact compare would let it run all the way round first.
  assign ref_tick = tb & (r_reg.div >= div_max);
  assign ext_rng = (r_reg.rng == `MFC_RNG_EXT);

  // Signal routing into the main and reference counters.
  always_comb begin
    main_ev = tb;
    ref_ev = 1'b0;
    unique case (r_reg.func)
      mfc_pkg::FN_PERIOD: begin
        ref_ev = a_fall;
      end
      mfc_pkg::FN_RATIO: begin
        main_ev = a_fall;
        ref_ev = b_fall;
      end
      mfc_pkg::FN_INTERVAL: begin
        // One reference count per closed A-then-B sequence.
        ref_ev = r_reg.ti_open & b_fall;
      end
      mfc_pkg::FN_UNIT: begin
        main_ev = a_fall;
      end
      mfc_pkg::FN_OSC: begin
        ref_ev = ref_tick;
      end
      default: begin
        main_ev = a_fall;
        ref_ev = ref_tick;
      end
    endcase
  end

  // Last reference count of the window for each range.
  always_comb begin
    unique case (r_reg.rng[1:0])
      2'h0: rmax = `MFC_R1_MAX;
      2'h1: rmax = `MFC_R10_MAX;
      2'h2: rmax = `MFC_R100_MAX;
      default: rmax = `MFC_R1K_MAX;
    endcase
  end

  // Window start and end; the external gate is only looked at on ticks.
  assign start = ext_rng ? (ref_tick & gate_hi) :
                 (r_reg.func == mfc_pkg::FN_INTERVAL) ? a_fall : ref_ev;
  assign done = ext_rng ? (ref_tick & ~gate_hi) :
                (ref_ev & (r_reg.refcnt == rmax));
  // In interval mode the oscillator is counted only between A and B.
  assign count_en = main_ev & ((r_reg.func != mfc_pkg::FN_INTERVAL) | r_reg.ti_open);

  // ****************************************************************
  // Next state
  // ****************************************************************

  always_comb begin
    r_next = r_reg;
    abort = 1'b0;

    // Read data is captured in the setup phase for a registered answer.
    if (setup) begin
      unique case (paddr)
        `MFC_ADDR_CTRL: r_next.prdata = {18'h00000, r_reg.point_digit, r_reg.ext_point,
                                         r_reg.ext_osc, r_reg.mhz1, r_reg.disp_test,
                                         r_reg.disp_off, r_reg.rng, r_reg.func};
        `MFC_ADDR_STAT: r_next.prdata = {28'h0000000, r_reg.ext_osc, r_reg.fallback,
                                         r_reg.res_ovf, measurement_active};
        `MFC_ADDR_RES:  r_next.prdata = {5'h00, r_reg.result};
        `MFC_ADDR_LIVE: r_next.prdata = {5'h00, r_reg.main};
        default:        r_next.prdata = 32'h00000000;
      endcase
    end

    // Options are independent bits so any combination can be set.
    // Selections change only at the access edge, so they stand still in between.
    if (wr_en && paddr == `MFC_ADDR_CTRL) begin
      r_next.func = (pwdata[2:0] > 3'h5) ? mfc_pkg::FN_FREQ :
                    mfc_pkg::mfc_func_t'(pwdata[2:0]);
      r_next.rng = (pwdata[5:3] > `MFC_RNG_EXT) ? `MFC_RNG_EXT : pwdata[5:3];
      r_next.disp_off = pwdata[6];
      r_next.disp_test = pwdata[7];
      r_next.mhz1 = pwdata[8];
      r_next.ext_osc = pwdata[9];
      r_next.ext_point = pwdata[10];
      r_next.point_digit = pwdata[13:11];
    end
    // Fallback flag is write-one-to-clear; a new fallback below still wins.
    if (wr_en && paddr == `MFC_ADDR_STAT && pwdata[1]) begin
      r_next.fallback = 1'b0;
    end

    // Two flops per input, a third for edge detection only on A, B and the alternate timebase.
    r_next.sa = {r_reg.sa[1:0], input_a};
    r_next.sb = {r_reg.sb[1:0], input_b};
    r_next.sg = {r_reg.sg[0], external_gate};
    r_next.st = {r_reg.st[1:0], alt_timebase_in};

    // Reference divider down to the 100Hz tick.
    if (tb) begin
      r_next.div = ref_tick ? 17'h00000 : r_reg.div + 17'h00001;
    end

    // A too slow alternate timebase is dropped for the internal clock.
    r_next.wd = 10'h000;
    if (r_reg.ext_osc && !alt_rise) begin
      if (r_reg.wd == WD_MAX) begin
        r_next.ext_osc = 1'b0;
        r_next.fallback = 1'b1;
        r_next.div = 17'h00000;
        abort = 1'b1;
      end else begin
        r_next.wd = r_reg.wd + 10'h001;
      end
    end

    // Selection changes are seen one cycle after the write.
    r_next.prev_func = r_reg.func;
    r_next.prev_rng = r_reg.rng;
    if (r_reg.func != r_reg.prev_func) begin
      abort = 1'b1;
    end
    if (r_reg.rng != r_reg.prev_rng && r_reg.func != mfc_pkg::FN_UNIT) begin
      abort = 1'b1;
    end

    if (r_reg.func == mfc_pkg::FN_UNIT && !abort) begin
      // Totalising: no window, the result tracks the counter unless frozen.
      r_next.state = mfc_pkg::ST_RUN;
      r_next.ti_open = 1'b0;
      if (!off_hold && count_en) begin
        if (r_reg.main == `MFC_CNT_MAX) begin
          r_next.ovf = 1'b1;
        end else begin
          r_next.main = r_reg.main + 27'h0000001;
        end
      end
      if (!freeze_in) begin
        r_next.result = r_reg.main;
        r_next.res_ovf = r_reg.ovf;
      end
    end else if (abort || (freeze_in && r_reg.state != mfc_pkg::ST_STORE)) begin
      // Aborted or held: counter cleared, displayed result untouched.
      r_next.state = mfc_pkg::ST_ARM;
      r_next.main = 27'h0000000;
      r_next.ovf = 1'b0;
      r_next.refcnt = 10'h000;
      r_next.ti_open = 1'b0;
    end else begin
      unique case (r_reg.state)
        mfc_pkg::ST_ARM: begin
          // Wait for the first reference edge so the window is aligned.
          r_next.main = 27'h0000000;
          r_next.ovf = 1'b0;
          r_next.refcnt = 10'h000;
          if (start) begin
            r_next.state = mfc_pkg::ST_RUN;
            r_next.ti_open = (r_reg.func == mfc_pkg::FN_INTERVAL) & a_fall;
          end
        end
        mfc_pkg::ST_RUN: begin
          if (count_en) begin
            if (r_reg.main == `MFC_CNT_MAX) begin
              r_next.ovf = 1'b1;
            end else begin
              r_next.main = r_reg.main + 27'h0000001;
            end
          end
          if (r_reg.func == mfc_pkg::FN_INTERVAL) begin
            // A opens a sequence, the next B closes it.
            if (!r_reg.ti_open && a_fall) begin
              r_next.ti_open = 1'b1;
            end else if (r_reg.ti_open && b_fall) begin
              r_next.ti_open = 1'b0;
            end
          end
          if (done) begin
            r_next.state = mfc_pkg::ST_STORE;
          end else if (ref_ev) begin
            r_next.refcnt = r_reg.refcnt + 10'h001;
          end
        end
        mfc_pkg::ST_STORE: begin
          // Latch the finished count, then pause before the next window.
          r_next.result = r_reg.main;
          r_next.res_ovf = r_reg.ovf;
          r_next.gap = 5'h00;
          r_next.ti_open = 1'b0;
          r_next.state = mfc_pkg::ST_GAP;
        end
        mfc_pkg::ST_GAP: begin
          r_next.main = 27'h0000000;
          if (ref_tick) begin
            if (r_reg.gap == GAP_MAX) begin
              r_next.state = mfc_pkg::ST_ARM;
            end else begin
              r_next.gap = r_reg.gap + 5'h01;
            end
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Reset clears everything, so the result, and thus the display, reads zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule // mfc_core
`default_nettype wire

/* File: mfc_end.sv */
// Empty unit.

/* File: mfc_checker.sv */
// Port-level assertions of the counter core, bound to its top module.
`timescale 1ns/100ps
`default_nettype none
module mfc_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        freeze_in,
  input wire logic        measurement_active,
  input wire logic        display_blank,
  input wire logic        display_test,
  input wire logic        overflow,
  input wire logic [3:0]  decimal_point_digit
);
  // ****************
  // Helper logic
  // ****************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [13:0] ctrl_reg;
  logic [1:0]  since_reg;
  // A shadow of the control word lets the options be judged from the ports alone.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg  <= 14'h0000;
      since_reg <= 2'h0;
    end else begin
      if (psel && penable && pwrite && paddr == 8'h00) begin
        ctrl_reg <= pwdata[13:0];
      end
      if (since_reg != 2'h3) begin
        since_reg <= since_reg + 2'h1;
      end
    end
  end
  // ****************
  // Assertions
  // ****************
  sequence s_frozen;
    (freeze_in && ctrl_reg[2:0] != 3'h4) [*3];
  endsequence
  sequence s_stored;
    $rose(measurement_active) && !freeze_in && ctrl_reg[2:0] != 3'h4;
  endsequence
  a_reset_idle: assert property (since_reg == 2'h1 |-> !measurement_active && !overflow)
    else $error("core not idle after reset");
  a_blank_freeze: assert property (display_blank |-> freeze_in && ctrl_reg[6])
    else $error("display blanked without cause");
  a_test_shown: assert property (display_test == (ctrl_reg[7] && !display_blank))
    else $error("display test output wrong");
  a_point_manual: assert property (ctrl_reg[10] |-> decimal_point_digit == ctrl_reg[13:11] + 4'h1)
    else $error("manual point digit wrong");
  a_point_external: assert property (!ctrl_reg[10] && ctrl_reg[5:3] >= 3'h4 |-> decimal_point_digit == 4'h0)
    else $error("point lit with external range");
  a_gap_high: assert property (s_stored |=> measurement_active)
    else $error("activity output not high after store");
  a_freeze_arms: assert property (s_frozen |-> !measurement_active)
    else $error("freeze did not hold the core armed");
  a_result_held: assert property (ctrl_reg[2:0] != 3'h4 && $changed(overflow) |-> measurement_active)
    else $error("overflow changed outside a store");
endmodule // mfc_checker
bind mfc_core mfc_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .freeze_in, .measurement_active, .display_blank, .display_test, .overflow,
  .decimal_point_digit);
`default_nettype wire

/* File: mfc_source.sv */
// Model of the signal sources that feed the measured inputs of the counter core.
`timescale 1ns/100ps
`default_nettype none
module mfc_source (
  input  wire logic       pclk,
  input  wire logic [7:0] per_a,
  input  wire logic [7:0] per_b,
  input  wire logic [7:0] lag_b,
  input  wire logic       alt_on,
  output var bit          input_a,
  output var bit          input_b,
  output var bit          alt_timebase_in
);
  // ****************
  // Waveforms
  // ****************
  int unsigned t;
  // One shared phase counter, so B falls exactly lag_b clocks after A when periods match.
  always_ff @(posedge pclk) begin
    t <= t + 1;
    input_a <= (t % per_a) < per_a / 2;
    input_b <= ((t + per_b - lag_b) % per_b) < per_b / 2;
    alt_timebase_in <= alt_on && t[1];
  end
endmodule // mfc_source
`default_nettype wire

/* File: mfc_core_tb.sv */
// Self-checking testbench of the counter core.
`timescale 1ns/100ps
`default_nettype none
module mfc_core_tb;
  // ****************
  // Signals
  // ****************
  localparam logic [31:0] OFF = 32'h40;
  localparam logic [31:0] TST = 32'h80;
  localparam logic [31:0] MHZ = 32'h100;
  localparam logic [31:0] EXO = 32'h200;
  localparam logic [31:0] MPT = 32'h400;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        external_gate = 1'b0;
  logic        freeze_in = 1'b0;
  logic        alt_on = 1'b0;
  logic [7:0]  per_a = 8'h05;
  logic [7:0]  per_b = 8'h28;
  logic [7:0]  lag_b = 8'h00;
  logic [31:0] rd, r1;
  logic        se;
  int          errors = 0;
  int          compares = 0;
  wire logic [31:0] prdata;
  wire logic [3:0]  decimal_point_digit;
  wire logic   pready, pslverr, input_a, input_b, alt_timebase_in;
  wire logic   measurement_active, display_blank, display_test, overflow;
  mfc_core #(.DIV_10M(10), .DIV_1M(2)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .input_a, .input_b, .alt_timebase_in,
    .external_gate, .freeze_in, .measurement_active, .display_blank, .display_test,
    .overflow, .decimal_point_digit);
  mfc_source src_u (.pclk, .per_a, .per_b, .lag_b, .alt_on, .input_a, .input_b,
    .alt_timebase_in);
  // ****************
  // Helpers
  // ****************
  // The clock runs freely at 100 MHz.
  initial begin
    forever #5 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic timeout();
    errors++;
    $display("Wait limit used up at %0t", $time);
    print_verdict();
  endtask
  // One APB transfer; the request stands until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) timeout();
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_act(input logic v);
    for (int k = 0; k < 5000 && measurement_active !== v; k++) @(posedge pclk);
    if (measurement_active !== v) timeout();
  endtask
  // A selection takes hold a cycle after its write, so older stores are let pass first.
  task automatic collect();
    repeat (2) @(posedge pclk);
    wait_act(1'b0);
    wait_act(1'b1);
    apb(1'b0, 8'h08, 32'h0);
  endtask
  function automatic logic [31:0] ctl(input int f, input int r);
    return 32'(f + r * 8);
  endfunction
  task automatic one(input int f, r, input logic [31:0] o, input logic [7:0] a, b, l);
    per_a <= a;
    per_b <= b;
    lag_b <= l;
    apb(1'b1, 8'h00, ctl(f, r) | o);
    collect();
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check({rd[30:0], se}, 32'h1);
    $display("reset test done");
  endtask
  task automatic t_freq();
    one(0, 0, 32'h0, 8'h05, 8'h28, 8'h00);
    check(rd, 32'h02);
    apb(1'b1, 8'h00, ctl(0, 1));
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h02);
    collect();
    check(rd, 32'h14);
    wait_act(1'b0);
    freeze_in <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(1'b0, 8'h0C, 32'h0);
    check(rd, 32'h0);
    freeze_in <= 1'b0;
    collect();
    check(rd, 32'h14);
    apb(1'b1, 8'h00, ctl(5, 1));
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h14);
    collect();
    check(rd, 32'h64);
    check({31'h0, overflow}, 32'h0);
    $display("frequency test done");
  endtask
  task automatic t_modes();
    one(1, 0, 32'h0, 8'h0A, 8'h28, 8'h00);
    check(rd, 32'h0A);
    check({28'h0, decimal_point_digit}, 32'h2);
    one(1, 0, MHZ, 8'h0A, 8'h28, 8'h00);
    check({28'h0, decimal_point_digit}, 32'h1);
    one(1, 1, 32'h0, 8'h0A, 8'h28, 8'h00);
    check(rd, 32'h64);
    one(2, 0, 32'h0, 8'h0A, 8'h28, 8'h00);
    check(rd, 32'h04);
    one(3, 0, 32'h0, 8'h14, 8'h14, 8'h07);
    check(rd, 32'h07);
    one(3, 1, 32'h0, 8'h14, 8'h14, 8'h07);
    check(rd, 32'h46);
    one(5, 0, MHZ, 8'h0A, 8'h28, 8'h00);
    check(rd, 32'h02);
    $display("mode test done");
  endtask
  task automatic t_unit();
    apb(1'b1, 8'h00, ctl(4, 0));
    repeat (20) @(posedge pclk);
    apb(1'b0, 8'h0C, 32'h0);
    r1 = rd;
    repeat (97) @(posedge pclk);
    apb(1'b0, 8'h0C, 32'h0);
    check(rd - r1, 32'h0A);
    freeze_in <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, 8'h08, 32'h0);
    r1 = rd;
    repeat (30) @(posedge pclk);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, r1);
    apb(1'b0, 8'h0C, 32'h0);
    check({31'h0, rd > r1}, 32'h1);
    freeze_in <= 1'b0;
    $display("unit test done");
  endtask
  task automatic t_display();
    apb(1'b1, 8'h00, OFF | TST);
    repeat (2) @(posedge pclk);
    check({display_blank, display_test}, 32'h1);
    freeze_in <= 1'b1;
    repeat (4) @(posedge pclk);
    check({display_blank, display_test}, 32'h2);
    freeze_in <= 1'b0;
    apb(1'b1, 8'h00, MPT | 32'h1800);
    // The write lands at the edge the task returns on, so let the register settle.
    @(posedge pclk);
    check({28'h0, decimal_point_digit}, 32'h4);
    $display("display test done");
  endtask
  task automatic t_gate();
    apb(1'b1, 8'h00, ctl(0, 4));
    repeat (30) @(posedge pclk);
    check({28'h0, decimal_point_digit}, 32'h0);
    external_gate <= 1'b1;
    repeat (35) @(posedge pclk);
    external_gate <= 1'b0;
    wait_act(1'b1);
    apb(1'b0, 8'h08, 32'h0);
    // Input A falls every ten cycles and the gate spans three or four reference ticks.
    check({31'h0, rd == 32'h3 || rd == 32'h4}, 32'h1);
    $display("gate test done");
  endtask
  task automatic t_osc();
    alt_on <= 1'b1;
    one(0, 0, EXO, 8'h05, 8'h28, 8'h00);
    check(rd, 32'h08);
    alt_on <= 1'b0;
    repeat (1100) @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0);
    check(rd[3:1], 32'h2);
    apb(1'b1, 8'h04, 32'h2);
    apb(1'b0, 8'h04, 32'h0);
    check(rd[3:1], 32'h0);
    $display("oscillator test done");
  endtask
  // Reset is held for six cycles, then every scenario runs in turn.
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_freq();
    t_modes();
    t_unit();
    t_display();
    t_gate();
    t_osc();
    print_verdict();
  end
endmodule // mfc_core_tb
`default_nettype wire
